// >>> pkg/cdm_pkg.sv
/*
 cell demux fifo constants: register map, reset values, sizes, port states.
 assumes a single 40 MHz bus clock for all logic.
*/
package cdm_pkg;
    localparam int NPORT = 4;
    localparam int WORD_W = 18;
    localparam int PTR_W = 6;
    localparam int OCC_W = 7;
    localparam int DEPTH = 64;
    localparam logic [6:0] DEPTH_WORDS = 7'h40;
    localparam logic [6:0] MIN_CELL_WORDS = 7'h08;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] CSIZE_OFS = 8'h04;
    localparam logic [7:0] CHIPID_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0C;
    localparam logic [7:0] LEVEL_OFS = 8'h10;
    localparam int BSS_BIT = 0;
    localparam int MCAST_BIT = 1;
    localparam int RMS_BIT = 2;
    localparam int MSE_BIT = 3;
    localparam int BNE_BIT = 4;
    localparam logic [4:0] CTRL_RST = 5'h18;
    localparam logic [6:0] CSIZE_RST = 7'h35;
    localparam logic [1:0] CHIPID_RST = 2'h0;
    typedef enum logic [2:0] {
        st_idle = 3'b001,
        st_fetch = 3'b010,
        st_send = 3'b100
    } port_state_e;
endpackage

// >>> hdl/cell_mem.sv
/*
 one queue store: 64 words of 18 bits, one write and one registered read.
 assumes the caller never reads and writes beyond its own pointers.
*/
`timescale 1ns/1ps
module cell_mem (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic wr_en,
    input wire logic [5:0] wr_addr,
    input wire logic [17:0] wr_data,
    input wire logic rd_en,
    input wire logic [5:0] rd_addr,
    output logic [17:0] rd_data
);
    logic [17:0] mem [cdm_pkg::DEPTH];

    // reset wipes every location
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < cdm_pkg::DEPTH; i++) begin
                mem[i] <= 18'h00000;
            end
        end else if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_data <= 18'h00000;
        end else if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule

// >>> hdl/out_port.sv
/*
 one output port: sends whole cells as master or slave, byte or nibble wide.
 assumes rd_data follows rd_en by one clock.
*/
`timescale 1ns/1ps
module out_port (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic master,
    input wire logic byte_mode,
    input wire logic [6:0] cell_words,
    input wire logic cells_ready,
    input wire logic cell_avail_in,
    input wire logic xfer_en_n_in,
    input wire logic [17:0] rd_data,
    output logic rd_en,
    output logic cell_done,
    output logic [8:0] data_out,
    output logic cell_start_out,
    output logic xfer_en_n_out,
    output logic xfer_en_n_oe
);
    cdm_pkg::port_state_e state_reg;
    logic [1:0] sub_reg;
    logic [6:0] word_cnt_reg;
    logic advance, last_sub, last_word, first;
    logic [8:0] cur_byte, part;
    logic [3:0] nib;

    assign advance = (state_reg == cdm_pkg::st_send) && (master || !xfer_en_n_in);
    assign last_sub = byte_mode ? sub_reg[0] : (sub_reg == 2'h3);
    assign last_word = (word_cnt_reg == cell_words - 7'h01);
    assign first = (word_cnt_reg == 7'h00) && (sub_reg == 2'h0);
    assign rd_en = (state_reg == cdm_pkg::st_fetch) || (advance && last_sub && !last_word);
    assign cell_done = advance && last_sub && last_word;
    assign cur_byte = (byte_mode ? sub_reg[0] : sub_reg[1]) ? rd_data[17:9] : rd_data[8:0];
    assign nib = sub_reg[0] ? cur_byte[7:4] : cur_byte[3:0];
    assign xfer_en_n_oe = master;

    // byte: full 9 bits; nibble: bit 8 held, bit 7 enable in master
    always_comb begin
        part = cur_byte;
        if (!byte_mode) begin
            part = {cur_byte[8], master, 3'h0, nib};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= cdm_pkg::st_idle;
        end else begin
            unique case (state_reg)
                cdm_pkg::st_idle: begin
                    if (cells_ready && cell_avail_in) begin
                        state_reg <= cdm_pkg::st_fetch;
                    end
                end
                cdm_pkg::st_fetch: begin
                    state_reg <= cdm_pkg::st_send;
                end
                cdm_pkg::st_send: begin
                    if (cell_done) begin
                        state_reg <= cdm_pkg::st_idle;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sub_reg <= 2'h0;
            word_cnt_reg <= 7'h00;
        end else if (state_reg == cdm_pkg::st_fetch) begin
            sub_reg <= 2'h0;
            word_cnt_reg <= 7'h00;
        end else if (advance) begin
            sub_reg <= last_sub ? 2'h0 : sub_reg + 2'h1;
            if (last_sub) begin
                word_cnt_reg <= word_cnt_reg + 7'h01;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            data_out <= 9'h000;
            cell_start_out <= 1'b0;
            xfer_en_n_out <= 1'b1;
        end else begin
            xfer_en_n_out <= !(advance && master);
            if (advance) begin
                data_out <= part;
                cell_start_out <= first;
            end else if (master) begin
                cell_start_out <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    master_xfer_a: assert property (advance && master |=> !xfer_en_n_out && data_out == $past(part))
        else $error("master transfer not driven");
    slave_step_a: assert property (state_reg == cdm_pkg::st_send && !master && !xfer_en_n_in
        |=> data_out == $past(part))
        else $error("slave nibble not updated");
    start_only_a: assert property (advance && !first |=> !cell_start_out)
        else $error("cell start beyond first transfer");
    clav_gate_a: assert property (state_reg == cdm_pkg::st_idle && !(cell_avail_in && cells_ready)
        |=> state_reg == cdm_pkg::st_idle)
        else $error("cell begun without permission");
    nibble_pad_a: assert property (!byte_mode && advance |=> data_out[6:4] == 3'h0
        && data_out[7] == master)
        else $error("nibble upper bits wrong");
    nibble_cov_c: cover property (!byte_mode && cell_done);
endmodule

// >>> hdl/cell_demux.sv
/*
 one-to-four cell demultiplexing queue with an AHB-Lite register slave.
 assumes inputs are synchronous to hclk and a zero-wait OKAY-only master.
*/
`timescale 1ns/1ps
//Contract
//- master port pulls enable low; a word moves in every such cycle
//- slave port presents the next nibble one edge after enable seen low
//- master byte mode sends a full 9-bit word each transfer
//- master nibble: bits 0-3 data, 4-6 zero, 7 enable, 8 ninth bit
//- slave nibble: bits 0-3 data, 4-7 zero, 8 ninth bit held
//- cell start output high only on a cell's first transfer
//- space available only when every selected queue fits a whole cell
//- bus size high: 9-bit input, upper lines configure; low: 18-bit input
//- 9-bit mode: data lines 11-17 load the cell size register
//- 9-bit mode: data lines 9-10 load chip identity bits 0-1
//- reset clears all storage and every queue pointer
//- single out-band route taken from five address lines
//- single in-band route taken from the input data lines
//- multicast out-band: address lines 0-3 enable queues, line 4 ignored
//- multicast in-band: queue set taken from the input data lines
//- multicast select high means multicast, low means single destination
//- routing method select high in-band, low out-band
//- master/slave select high makes ports masters, low slaves
//- byte/nibble select high byte wide, low nibble on bits 0-3
module cell_demux (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [17:0] in_data,
    input wire logic in_write_enable,
    input wire logic in_cell_start,
    input wire logic [4:0] route_addr_lines,
    output logic in_cell_space_avail,
    output logic [3:0][8:0] port_data,
    output logic [3:0] port_cell_start_out,
    input wire logic [3:0] port_cell_avail_in,
    input wire logic [3:0] port_xfer_enable_n_in,
    output logic [3:0] port_xfer_enable_n_out,
    output logic [3:0] port_xfer_enable_n_oe
);
    logic [4:0] ctrl_reg;
    logic [6:0] cell_size_reg;
    logic [1:0] chip_id_reg;
    logic bus_size_select, mcast, routing_method_select, master_slave_select, byte_nibble_select;
    logic ph_valid_reg, ph_write_reg, ph_hit_reg, rd_done_reg;
    logic [7:0] ph_addr_reg;
    logic [4:0] wsel;
    logic [31:0] rd_mux;
    logic [6:0] cs_words, cell_words, pending, words_now;
    logic [7:0] need;
    logic start_fire, active, half_now, word_fire, last_word, pin_load;
    logic in_cell_reg, byte_half_reg;
    logic [8:0] low_byte_reg;
    logic [6:0] words_done_reg;
    logic [3:0] cell_mask_reg, out_mask, mask_now, clav_mask, space_ok;
    logic [17:0] wr_word;
    logic [3:0] wr_en, rd_en, cell_done, cells_ready;
    logic [3:0][5:0] wr_ptr_reg, rd_ptr_reg;
    logic [3:0][6:0] occ_reg;
    logic [3:0][3:0] cells_reg;
    logic [3:0][17:0] rd_data;
    logic [8:0] occ_sum;

    // address decode for the word-aligned register map
    function automatic logic [4:0] reg_decode(input logic [7:0] a, input logic hit);
        logic [4:0] s;
        s = 5'h00;
        if (hit) begin
            s[0] = (a == cdm_pkg::CTRL_OFS);
            s[1] = (a == cdm_pkg::CSIZE_OFS);
            s[2] = (a == cdm_pkg::CHIPID_OFS);
            s[3] = (a == cdm_pkg::STATUS_OFS);
            s[4] = (a == cdm_pkg::LEVEL_OFS);
        end
        return s;
    endfunction

    // route field to queue set
    function automatic logic [3:0] route_mask(input logic [4:0] a, input logic [1:0] id,
                                              input logic mc);
        logic [3:0] m;
        m = 4'h0;
        if (mc) begin
            m = a[3:0];
        end else if (!a[4] && a[3:2] == id) begin
            m = 4'h1 << a[1:0];
        end
        return m;
    endfunction

    assign bus_size_select = ctrl_reg[cdm_pkg::BSS_BIT];
    assign mcast = ctrl_reg[cdm_pkg::MCAST_BIT];
    assign routing_method_select = ctrl_reg[cdm_pkg::RMS_BIT];
    assign master_slave_select = ctrl_reg[cdm_pkg::MSE_BIT];
    assign byte_nibble_select = ctrl_reg[cdm_pkg::BNE_BIT];

    // bus slave: writes zero-wait, reads one wait state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_valid_reg <= 1'b0;
            ph_write_reg <= 1'b0;
            ph_hit_reg <= 1'b0;
            ph_addr_reg <= 8'h00;
        end else if (hready) begin
            ph_valid_reg <= hsel && htrans[1];
            ph_write_reg <= hwrite;
            ph_hit_reg <= (haddr[31:8] == 24'h000000);
            ph_addr_reg <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_done_reg <= 1'b0;
        end else if (hready) begin
            rd_done_reg <= 1'b0;
        end else if (ph_valid_reg && !ph_write_reg) begin
            rd_done_reg <= 1'b1;
        end
    end

    assign hreadyout = !(ph_valid_reg && !ph_write_reg && !rd_done_reg);
    assign hresp = 1'b0;
    assign wsel = reg_decode(ph_addr_reg, ph_hit_reg);

    always_comb begin
        rd_mux = 32'h00000000;
        unique case (1'b1)
            wsel[0]: rd_mux = {27'h0, ctrl_reg};
            wsel[1]: rd_mux = {25'h0, cell_size_reg};
            wsel[2]: rd_mux = {30'h0, chip_id_reg};
            wsel[3]: rd_mux = {26'h0, in_cell_reg, in_cell_space_avail, cells_ready};
            wsel[4]: rd_mux = {1'b0, occ_reg[3], 1'b0, occ_reg[2],
                               1'b0, occ_reg[1], 1'b0, occ_reg[0]};
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (ph_valid_reg && !ph_write_reg && !rd_done_reg) begin
            hrdata <= rd_mux;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= cdm_pkg::CTRL_RST;
        end else if (ph_valid_reg && ph_write_reg && wsel[0]) begin
            ctrl_reg <= hwdata[4:0];
        end
    end

    // in 9-bit mode the upper data lines own size and identity while idle
    assign pin_load = bus_size_select && !in_cell_reg && !start_fire;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cell_size_reg <= cdm_pkg::CSIZE_RST;
            chip_id_reg <= cdm_pkg::CHIPID_RST;
        end else if (pin_load) begin
            cell_size_reg <= in_data[17:11];
            chip_id_reg <= in_data[10:9];
        end else if (ph_valid_reg && ph_write_reg) begin
            if (wsel[1]) begin
                cell_size_reg <= hwdata[6:0];
            end
            if (wsel[2]) begin
                chip_id_reg <= hwdata[1:0];
            end
        end
    end

    // input side
    assign cs_words = {1'b0, cell_size_reg[6:1]} + 7'h01;
    assign cell_words = (cs_words < cdm_pkg::MIN_CELL_WORDS) ? cdm_pkg::MIN_CELL_WORDS : cs_words;
    assign out_mask = route_mask(route_addr_lines, chip_id_reg, mcast);
    assign start_fire = in_write_enable && in_cell_start;
    assign active = start_fire || (in_write_enable && in_cell_reg);
    assign half_now = start_fire ? 1'b0 : byte_half_reg;
    assign word_fire = active && (!bus_size_select || half_now);
    assign words_now = start_fire ? 7'h00 : words_done_reg;
    assign last_word = word_fire && (words_now == cell_words - 7'h01);
    assign wr_word = bus_size_select ? {in_data[8:0], low_byte_reg} : in_data;

    always_comb begin
        mask_now = cell_mask_reg;
        if (start_fire) begin
            mask_now = routing_method_select ? route_mask(in_data[4:0], chip_id_reg, mcast)
                           : out_mask;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            in_cell_reg <= 1'b0;
            byte_half_reg <= 1'b0;
            low_byte_reg <= 9'h000;
            words_done_reg <= 7'h00;
            cell_mask_reg <= 4'h0;
        end else begin
            if (start_fire) begin
                cell_mask_reg <= mask_now;
                in_cell_reg <= !last_word;
            end else if (last_word) begin
                in_cell_reg <= 1'b0;
            end
            if (active) begin
                byte_half_reg <= bus_size_select && !half_now;
                if (bus_size_select && !half_now) begin
                    low_byte_reg <= in_data[8:0];
                end
            end
            if (word_fire) begin
                words_done_reg <= last_word ? 7'h00 : words_now + 7'h01;
            end else if (start_fire) begin
                words_done_reg <= 7'h00;
            end
        end
    end

    // space check covers the rest of the open cell plus one more cell
    assign pending = in_cell_reg ? cell_words - words_done_reg : 7'h00;
    assign need = {1'b0, cell_words} + {1'b0, pending};
    assign clav_mask = routing_method_select ? 4'hF : out_mask;
    assign in_cell_space_avail = (|clav_mask) && (&(space_ok | ~clav_mask));

    // single clock: both pointer sets live in one domain, no crossing needed
    generate
        for (genvar p = 0; p < cdm_pkg::NPORT; p++) begin : g_port
            assign wr_en[p] = word_fire && mask_now[p] && (occ_reg[p] != cdm_pkg::DEPTH_WORDS);
            assign space_ok[p] = ({1'b0, cdm_pkg::DEPTH_WORDS - occ_reg[p]} >= need);
            assign cells_ready[p] = (cells_reg[p] != 4'h0);

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    wr_ptr_reg[p] <= 6'h00;
                    rd_ptr_reg[p] <= 6'h00;
                    occ_reg[p] <= 7'h00;
                    cells_reg[p] <= 4'h0;
                end else begin
                    wr_ptr_reg[p] <= wr_ptr_reg[p] + {5'h00, wr_en[p]};
                    rd_ptr_reg[p] <= rd_ptr_reg[p] + {5'h00, rd_en[p]};
                    occ_reg[p] <= occ_reg[p] + {6'h00, wr_en[p]} - {6'h00, rd_en[p]};
                    cells_reg[p] <= cells_reg[p] + {3'h0, last_word && mask_now[p]}
                                    - {3'h0, cell_done[p]};
                end
            end

            cell_mem u_mem (
                .hclk(hclk),
                .hresetn(hresetn),
                .wr_en(wr_en[p]),
                .wr_addr(wr_ptr_reg[p]),
                .wr_data(wr_word),
                .rd_en(rd_en[p]),
                .rd_addr(rd_ptr_reg[p]),
                .rd_data(rd_data[p])
            );

            out_port u_port (
                .hclk(hclk),
                .hresetn(hresetn),
                .master(master_slave_select),
                .byte_mode(byte_nibble_select),
                .cell_words(cell_words),
                .cells_ready(cells_ready[p]),
                .cell_avail_in(port_cell_avail_in[p]),
                .xfer_en_n_in(port_xfer_enable_n_in[p]),
                .rd_data(rd_data[p]),
                .rd_en(rd_en[p]),
                .cell_done(cell_done[p]),
                .data_out(port_data[p]),
                .cell_start_out(port_cell_start_out[p]),
                .xfer_en_n_out(port_xfer_enable_n_out[p]),
                .xfer_en_n_oe(port_xfer_enable_n_oe[p])
            );
        end
    endgenerate

    assign occ_sum = {2'h0, occ_reg[0]} + {2'h0, occ_reg[1]}
                     + {2'h0, occ_reg[2]} + {2'h0, occ_reg[3]};

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    no_store_a: assert property (!in_write_enable |=> occ_sum <= $past(occ_sum))
        else $error("word stored without write enable");
    space_fit_a: assert property (in_cell_space_avail |-> (&(space_ok | ~clav_mask))
        && (occ_reg[0] + need <= 8'h40 || !clav_mask[0]))
        else $error("space flagged without room");
    wide_write_a: assert property (!bus_size_select && in_write_enable && in_cell_start && mask_now[0]
        && occ_reg[0] != 7'h40 |=> occ_reg[0] != 7'h00)
        else $error("18-bit word not written");
    pin_size_a: assert property (pin_load |=> cell_size_reg == $past(in_data[17:11])
        && chip_id_reg == $past(in_data[10:9]))
        else $error("pin load of size or identity failed");
    reset_clear_a: assert property ($past(!hresetn) |-> occ_sum == 9'h000
        && wr_ptr_reg == 24'h0 && rd_ptr_reg == 24'h0)
        else $error("pointers not cleared by reset");
    single_route_a: assert property (start_fire && !mcast && !routing_method_select
        |-> $countones(mask_now) <= 1)
        else $error("single route selects several queues");
    mcast_route_a: assert property (start_fire && mcast && !routing_method_select
        |=> cell_mask_reg == $past(route_addr_lines[3:0]))
        else $error("multicast enables not followed");
    inband_route_a: assert property (start_fire && routing_method_select
        |=> cell_mask_reg == route_mask($past(in_data[4:0]), chip_id_reg, mcast))
        else $error("in-band route not taken from data");
    read_wait_a: assert property (hready && hsel && htrans[1] && !hwrite
        |=> !hreadyout ##1 hreadyout)
        else $error("read answer timing wrong");

    mcast_cov_c: cover property (start_fire && mcast && $countones(mask_now) > 1);
    full_cell_c: cover property (last_word ##[1:100] (|cell_done));
    ahb_read_c: cover property (!hreadyout ##1 hreadyout);
endmodule

// >>> tb/cell_rx_model.sv
/*
 downstream cell receivers for the four output ports.
 assumes the bench raises permit per port when a receiver may take a cell.
*/
`timescale 1ns/1ps
module cell_rx_model (
    input wire logic [3:0] permit,
    input wire logic [3:0] en_n_out,
    input wire logic [3:0] en_n_oe,
    output logic [3:0] cell_avail,
    output logic [3:0] en_n_wire
);
    // receiver allows a cell only while permitted
    assign cell_avail = permit;
    // enable pin level: device drives it, else receiver pulls low while taking
    assign en_n_wire = (en_n_oe & en_n_out) | (~en_n_oe & ~permit);
endmodule

// >>> tb/cell_demux_tb.sv
/*
 bench for cell_demux: register bus, routing, master byte cells, reset.
 assumes cell_rx_model stands in for the receivers.
*/
`timescale 1ns/1ps
module cell_demux_tb;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, iwe = 0, ics = 0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0] htrans = '0;
    logic [17:0] in_data = '0;
    logic [4:0] route = '0;
    logic hreadyout, hresp, space;
    logic [3:0][8:0] port_data;
    logic [3:0] start_out, avail, en_in, en_out, en_oe, permit = '0;
    int bad_count = 0, total_checks = 0;

    cell_demux uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .in_data(in_data), .in_write_enable(iwe), .in_cell_start(ics),
        .route_addr_lines(route), .in_cell_space_avail(space), .port_data(port_data),
        .port_cell_start_out(start_out), .port_cell_avail_in(avail),
        .port_xfer_enable_n_in(en_in), .port_xfer_enable_n_out(en_out),
        .port_xfer_enable_n_oe(en_oe));
    cell_rx_model rx (.permit(permit), .en_n_out(en_out), .en_n_oe(en_oe),
        .cell_avail(avail), .en_n_wire(en_in));

    initial forever #12.5 hclk = ~hclk;

    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic timed_out;
        bad_count++;
        $display("MISMATCH %0t wait ran out", $time);
        complete_run();
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
        int n;
        logic rdy;
        hsel <= 1'b1; htrans <= 2'b10; haddr <= a; hwrite <= w;
        n = 0;
        do begin
            @(negedge hclk); rdy = hreadyout; @(posedge hclk); n++;
        end while (rdy !== 1'b1 && n < 50);
        if (n >= 50) timed_out();
        htrans <= 2'b00; hwdata <= wd;
        n = 0;
        do begin
            @(negedge hclk); rdy = hreadyout; rd = hrdata; @(posedge hclk); n++;
        end while (rdy !== 1'b1 && n < 50);
        if (n >= 50) timed_out();
    endtask

    task automatic send_cell(input logic [4:0] r, input logic [17:0] b);
        for (int i = 0; i < 9; i++) begin
            @(posedge hclk);
            iwe <= (i != 4);
            ics <= (i == 0);
            route <= r;
            in_data <= (i == 4) ? 18'h3FFFF : b + 18'(i - int'(i > 4));
        end
        @(posedge hclk);
        iwe <= 1'b0; ics <= 1'b0; in_data <= 18'h15555;
    endtask

    task automatic expect_cell(input int p, input logic [17:0] b);
        int n;
        logic [17:0] w;
        n = 0;
        permit[p] <= 1'b1;
        do begin @(negedge hclk); n++; end while (en_out[p] !== 1'b0 && n < 40);
        if (n >= 40) timed_out();
        for (int k = 0; k < 16; k++) begin
            w = b + 18'(k / 2);
            check(32'({en_out[p], start_out[p], port_data[p]}),
                32'({1'b0, k == 0, k[0] ? w[17:9] : w[8:0]}), "byte");
            @(negedge hclk);
        end
        check(32'(en_out[p]), 32'h1, "enable after cell");
        @(posedge hclk);
        permit[p] <= 1'b0;
    endtask

    task automatic t_regs;
        ahb(1'b0, 32'(cdm_pkg::CTRL_OFS), '0);
        check(rd, 32'(cdm_pkg::CTRL_RST), "ctrl reset");
        ahb(1'b0, 32'(cdm_pkg::CSIZE_OFS), '0);
        check(rd, 32'(cdm_pkg::CSIZE_RST), "size reset");
        ahb(1'b0, 32'h0000_0040, '0);
        check(rd, 32'h0, "unmapped");
        route <= 5'b00110;
        repeat (2) @(posedge hclk);
        check(32'(space), 32'h0, "foreign chip space");
        route <= 5'b00010;
        repeat (2) @(posedge hclk);
        check(32'(space), 32'h1, "own port space");
        $display("test regs done");
    endtask

    task automatic t_single;
        ahb(1'b1, 32'(cdm_pkg::CSIZE_OFS), 32'h0000_000E);
        send_cell(5'b00010, 18'h2A5A5);
        ahb(1'b0, 32'(cdm_pkg::LEVEL_OFS), '0);
        check(rd, 32'h0008_0000, "single level");
        expect_cell(2, 18'h2A5A5);
        $display("test single done");
    endtask

    task automatic t_mcast;
        ahb(1'b1, 32'(cdm_pkg::CTRL_OFS), 32'h0000_001A);
        send_cell(5'b10101, 18'h10F0F);
        ahb(1'b0, 32'(cdm_pkg::LEVEL_OFS), '0);
        check(rd, 32'h0008_0008, "mcast level");
        expect_cell(0, 18'h10F0F);
        expect_cell(2, 18'h10F0F);
        send_cell(5'b01000, 18'h00123);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b0, 32'(cdm_pkg::LEVEL_OFS), '0);
        check(rd, 32'h0, "level after reset");
        ahb(1'b0, 32'(cdm_pkg::CTRL_OFS), '0);
        check(rd, 32'(cdm_pkg::CTRL_RST), "ctrl after reset");
        $display("test mcast done");
    endtask

    task automatic t_inband;
        ahb(1'b1, 32'(cdm_pkg::CSIZE_OFS), 32'h0000_000E);
        ahb(1'b1, 32'(cdm_pkg::CTRL_OFS), 32'h0000_001C);
        send_cell(5'b00000, 18'h00003);
        ahb(1'b0, 32'(cdm_pkg::LEVEL_OFS), '0);
        check(rd, 32'h0800_0000, "inband level");
        expect_cell(3, 18'h00003);
        $display("test inband done");
    endtask

    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_single();
        t_mcast();
        t_inband();
        complete_run();
    end
endmodule
